/* dss_mem_model.sv */
// dss_mem_model: shared memory and bus arbiter beside the dma port
// assumes one clock, words addressed by mem_addr[13:2], slow answers
`timescale 1ns/1ps
module dss_mem_model #(
  parameter int ACK_DLY = 3
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        bus_req,
  output logic             bus_gnt,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack
);
  logic [31:0] mem [0:4095];
  int          cnt;
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 32'h0000_0000;
    end
  end
  // grant one cycle late, ack after ACK_DLY, data inverted once taken
  always @(posedge mclk) begin
    if (rst) begin
      bus_gnt   <= 1'b0;
      mem_ack   <= 1'b0;
      cnt       <= 0;
      mem_rdata <= 32'hA5A5_A5A5;
    end else begin
      bus_gnt <= bus_req;
      if (mem_req && mem_ack) begin
        if (mem_we) begin
          mem[mem_addr[13:2]] <= mem_wdata;
        end
        mem_ack   <= 1'b0;
        cnt       <= 0;
        mem_rdata <= ~mem_rdata;
      end else if (mem_req && cnt == ACK_DLY) begin
        mem_ack   <= 1'b1;
        mem_rdata <= mem[mem_addr[13:2]];
      end else if (mem_req) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

/* dss_pkg.sv */
// dss_pkg: register map, field positions, vectors and engine states
// assumes 32-bit apb data, one aligned word per register
package dss_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_GCMD   = 8'h00;
  localparam logic [7:0] OFS_GSTAT  = 8'h04;
  localparam logic [7:0] OFS_GCLR   = 8'h08;
  localparam logic [7:0] OFS_GIEN   = 8'h0C;
  localparam logic [7:0] OFS_CCFG0  = 8'h10;
  localparam logic [7:0] OFS_CCFG2  = 8'h14;
  localparam logic [7:0] OFS_BRXD   = 8'h18;
  localparam logic [7:0] OFS_BTXD   = 8'h1C;
  localparam logic [7:0] OFS_GLOBAL_MODE_REG  = 8'h20;
  localparam logic [7:0] OFS_ENGST  = 8'h24;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CMD_AR_BIT    = 0;
  localparam int CMD_IQI_BIT   = 1;
  localparam int CMD_RXC_BIT   = 2;
  localparam int CMD_TXC_BIT   = 3;
  localparam int ST_ACK_BIT    = 0;
  localparam int ST_TXI_BIT    = 1;
  localparam int ST_RXI_BIT    = 2;
  localparam int NSTAT         = 3;
  localparam int CC0_PU_BIT    = 0;
  localparam int CC0_TXRST_BIT = 1;
  localparam int CC2_RAC_BIT   = 0;
  localparam int GM_DMA_CONTROL_SELECT_BIT  = 0;
  localparam int DESC_STOP_BIT = 31;
  // ****************************************
  // reset values and vectors
  // ****************************************
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [31:0] VEC_CFG_QINIT = 32'h0000_0001;
  localparam logic [31:0] VEC_CFG_CHAN  = 32'h0000_0002;
  localparam logic [31:0] VEC_TX        = 32'h0000_0010;
  localparam logic [31:0] VEC_RX        = 32'h0000_0020;
  localparam logic [31:0] DATA_OFS      = 32'h0000_0004;
  localparam logic [1:0]  VK_CFG        = 2'h0;
  localparam logic [1:0]  VK_TX         = 2'h1;
  localparam logic [1:0]  VK_RX         = 2'h2;
  typedef enum logic [3:0] {
    S_READY    = 4'h0,
    S_QINIT    = 4'h1,
    S_BUSREQ   = 4'h2,
    S_CHCFG    = 4'h3,
    S_FETCH_RX = 4'h4,
    S_FETCH_TX = 4'h5,
    S_TX_DATA  = 4'h6,
    S_RX_STORE = 4'h7,
    S_VEC      = 4'h8
  } dss_state_t;
endpackage

/* dss_sequencer.sv */
// dss_sequencer: apb registers, start-up sequencing and descriptor dma
// assumes serial channel and memory port logic on mclk, single-cycle ack
`timescale 1ns/1ps
module dss_sequencer
  import dss_pkg::*;
#(
  parameter logic [31:0] CFGQ_BASE = 32'h0000_1000,
  parameter logic [31:0] TXQ_BASE  = 32'h0000_2000,
  parameter logic [31:0] RXQ_BASE  = 32'h0000_3000,
  parameter int          QIDX_W    = 4
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             bus_req,
  input  wire logic        bus_gnt,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic      [31:0] tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [31:0] rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic        ser_tx_irq,
  input  wire logic        ser_rx_irq,
  output logic             ser_power_up,
  output logic             ser_tx_reset,
  output logic             ser_rx_enable
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    dss_state_t        state;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic              cmd_pend;
    logic              cmd_iqi;
    logic              cmd_rxc;
    logic              cmd_txc;
    logic              busy;
    logic              running;
    logic [NSTAT-1:0]  status;
    logic [NSTAT-1:0]  ien;
    logic              irq;
    logic              pu;
    logic              txrst;
    logic              receiver_active;
    logic              dma_control_select;
    logic [31:0]       brxd;
    logic [31:0]       btxd;
    logic [31:0]       rx_ptr;
    logic [31:0]       tx_ptr;
    logic [31:0]       rx_link;
    logic [31:0]       tx_link;
    logic              rx_hold;
    logic              tx_hold;
    logic              bus_req;
    logic              mem_req;
    logic              mem_we;
    logic [31:0]       mem_addr;
    logic [31:0]       mem_wdata;
    logic [31:0]       tx_data;
    logic              tx_valid;
    logic [31:0]       rx_word;
    logic              rx_full;
    logic              rx_ready;
    logic              vcfg;
    logic [31:0]       vcfg_code;
    logic              vtx;
    logic              vrx;
    logic [1:0]        vkind;
    logic [QIDX_W-1:0] cfgq_idx;
    logic [QIDX_W-1:0] txq_idx;
    logic [QIDX_W-1:0] rxq_idx;
  } dss_st_t;

  dss_st_t          s_reg;
  dss_st_t          s_next;
  logic [NSTAT-1:0] clr;
  logic [NSTAT-1:0] set;
  logic             wr;
  logic             done;

  function automatic logic [31:0] qaddr(input logic [31:0] base,
                                        input logic [QIDX_W-1:0] idx);
    qaddr = base + 32'({idx, 2'b00});
  endfunction

  function automatic logic [31:0] next_ptr(input logic [31:0] link);
    next_ptr = {1'b0, link[30:2], 2'b00};
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    clr = '0;
    set = '0;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.txrst = 1'b0;
    wr = psel & penable & s_reg.pready & pwrite & ~s_reg.pslverr;
    done = s_reg.mem_req & mem_ack;
    if (psel & ~penable) begin
      s_next.pready = 1'b1;
      s_next.prdata = RST_WORD;
      unique case (paddr)
        OFS_GCMD: s_next.prdata = RST_WORD;
        OFS_GSTAT: s_next.prdata[NSTAT-1:0] = s_reg.status;
        OFS_GCLR: s_next.prdata = RST_WORD;
        OFS_GIEN: s_next.prdata[NSTAT-1:0] = s_reg.ien;
        OFS_CCFG0: s_next.prdata[CC0_PU_BIT] = s_reg.pu;
        OFS_CCFG2: s_next.prdata[CC2_RAC_BIT] = s_reg.receiver_active;
        OFS_BRXD: s_next.prdata = s_reg.brxd;
        OFS_BTXD: s_next.prdata = s_reg.btxd;
        OFS_GLOBAL_MODE_REG: s_next.prdata[GM_DMA_CONTROL_SELECT_BIT] = s_reg.dma_control_select;
        OFS_ENGST: s_next.prdata[7:0] = {s_reg.state, s_reg.running,
                                         s_reg.busy, s_reg.tx_hold, s_reg.rx_hold};
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        OFS_GCMD: begin
          if (pwdata[CMD_AR_BIT] & ~s_reg.busy & ~s_reg.cmd_pend) begin
            s_next.cmd_pend = 1'b1;
            s_next.cmd_iqi = pwdata[CMD_IQI_BIT];
            s_next.cmd_rxc = pwdata[CMD_RXC_BIT];
            s_next.cmd_txc = pwdata[CMD_TXC_BIT];
          end
        end
        OFS_GSTAT: clr = pwdata[NSTAT-1:0];
        OFS_GCLR: clr = pwdata[NSTAT-1:0];
        OFS_GIEN: s_next.ien = pwdata[NSTAT-1:0];
        OFS_CCFG0: begin
          s_next.pu = pwdata[CC0_PU_BIT];
          s_next.txrst = pwdata[CC0_TXRST_BIT];
          if (pwdata[CC0_TXRST_BIT]) begin
            s_next.tx_valid = 1'b0;
          end
        end
        OFS_CCFG2: s_next.receiver_active = pwdata[CC2_RAC_BIT];
        OFS_BRXD: s_next.brxd = pwdata;
        OFS_BTXD: s_next.btxd = pwdata;
        OFS_GLOBAL_MODE_REG: s_next.dma_control_select = pwdata[GM_DMA_CONTROL_SELECT_BIT];
        default: s_next.dma_control_select = s_reg.dma_control_select;
      endcase
    end
    if (s_reg.tx_valid & tx_ready) begin
      s_next.tx_valid = 1'b0;
    end
    if (rx_valid & s_reg.rx_ready) begin
      s_next.rx_word = rx_data;
      s_next.rx_full = 1'b1;
    end
    if (done) begin
      s_next.mem_req = 1'b0;
    end
    unique case (s_reg.state)
      S_READY: begin
        if (s_reg.cmd_pend) begin
          s_next.cmd_pend = 1'b0;
          if (s_reg.cmd_iqi) begin
            s_next.busy = 1'b1;
            s_next.state = S_QINIT;
          end else if (s_reg.cmd_rxc | s_reg.cmd_txc) begin
            s_next.busy = 1'b1;
            s_next.bus_req = 1'b1;
            s_next.state = S_BUSREQ;
          end
        end else if (s_reg.vcfg | s_reg.vtx | s_reg.vrx) begin
          s_next.state = S_VEC;
          s_next.mem_req = 1'b1;
          s_next.mem_we = 1'b1;
          if (s_reg.vcfg) begin
            s_next.vkind = VK_CFG;
            s_next.mem_addr = qaddr(CFGQ_BASE, s_reg.cfgq_idx);
            s_next.mem_wdata = s_reg.vcfg_code;
          end else if (s_reg.vtx) begin
            s_next.vkind = VK_TX;
            s_next.mem_addr = qaddr(TXQ_BASE, s_reg.txq_idx);
            s_next.mem_wdata = VEC_TX;
          end else begin
            s_next.vkind = VK_RX;
            s_next.mem_addr = qaddr(RXQ_BASE, s_reg.rxq_idx);
            s_next.mem_wdata = VEC_RX;
          end
        end else if (s_reg.running & s_reg.cmd_txc & ~s_reg.tx_valid &
                     ~s_reg.tx_hold) begin
          s_next.state = S_TX_DATA;
          s_next.mem_req = 1'b1;
          s_next.mem_we = 1'b0;
          s_next.mem_addr = s_reg.tx_ptr + DATA_OFS;
        end else if (s_reg.running & s_reg.rx_full & ~s_reg.rx_hold) begin
          s_next.state = S_RX_STORE;
          s_next.mem_req = 1'b1;
          s_next.mem_we = 1'b1;
          s_next.mem_addr = s_reg.rx_ptr + DATA_OFS;
          s_next.mem_wdata = s_reg.rx_word;
        end
      end
      S_QINIT: begin
        s_next.cfgq_idx = '0;
        s_next.txq_idx = '0;
        s_next.rxq_idx = '0;
        set[ST_ACK_BIT] = 1'b1;
        s_next.vcfg = 1'b1;
        s_next.vcfg_code = VEC_CFG_QINIT;
        s_next.busy = 1'b0;
        s_next.state = S_READY;
      end
      S_BUSREQ: begin
        if (bus_gnt) begin
          s_next.state = S_CHCFG;
        end
      end
      S_CHCFG: begin
        s_next.rx_ptr = s_reg.brxd;
        s_next.tx_ptr = s_reg.btxd;
        s_next.rx_hold = 1'b0;
        s_next.tx_hold = 1'b0;
        set[ST_ACK_BIT] = 1'b1;
        s_next.vcfg = 1'b1;
        s_next.vcfg_code = VEC_CFG_CHAN;
        s_next.mem_req = 1'b1;
        s_next.mem_we = 1'b0;
        s_next.mem_addr = s_reg.brxd;
        s_next.state = S_FETCH_RX;
      end
      S_FETCH_RX: begin
        if (done) begin
          s_next.rx_link = mem_rdata;
          if (s_reg.busy) begin
            s_next.mem_req = 1'b1;
            s_next.mem_addr = s_reg.tx_ptr;
            s_next.state = S_FETCH_TX;
          end else begin
            s_next.state = S_READY;
          end
        end
      end
      S_FETCH_TX: begin
        if (done) begin
          s_next.tx_link = mem_rdata;
          if (s_reg.busy) begin
            s_next.busy = 1'b0;
            s_next.bus_req = 1'b0;
            s_next.running = 1'b1;
          end
          s_next.state = S_READY;
        end
      end
      S_TX_DATA: begin
        if (done) begin
          s_next.tx_data = mem_rdata;
          s_next.tx_valid = 1'b1;
          if (~s_reg.dma_control_select & s_reg.tx_link[DESC_STOP_BIT]) begin
            s_next.tx_hold = 1'b1;
            s_next.state = S_READY;
          end else begin
            s_next.tx_ptr = next_ptr(s_reg.tx_link);
            s_next.mem_req = 1'b1;
            s_next.mem_addr = next_ptr(s_reg.tx_link);
            s_next.state = S_FETCH_TX;
          end
        end
      end
      S_RX_STORE: begin
        if (done) begin
          s_next.rx_full = 1'b0;
          s_next.mem_we = 1'b0;
          if (~s_reg.dma_control_select & s_reg.rx_link[DESC_STOP_BIT]) begin
            s_next.rx_hold = 1'b1;
            s_next.state = S_READY;
          end else begin
            s_next.rx_ptr = next_ptr(s_reg.rx_link);
            s_next.mem_req = 1'b1;
            s_next.mem_addr = next_ptr(s_reg.rx_link);
            s_next.state = S_FETCH_RX;
          end
        end
      end
      S_VEC: begin
        if (done) begin
          s_next.mem_we = 1'b0;
          s_next.state = S_READY;
          unique case (s_reg.vkind)
            VK_CFG: begin
              s_next.vcfg = 1'b0;
              s_next.cfgq_idx = QIDX_W'(s_reg.cfgq_idx + 1'b1);
            end
            VK_TX: begin
              s_next.vtx = 1'b0;
              s_next.txq_idx = QIDX_W'(s_reg.txq_idx + 1'b1);
            end
            default: begin
              s_next.vrx = 1'b0;
              s_next.rxq_idx = QIDX_W'(s_reg.rxq_idx + 1'b1);
            end
          endcase
        end
      end
      default: s_next.state = S_READY;
    endcase
    set[ST_TXI_BIT] = ser_tx_irq & s_reg.pu;
    set[ST_RXI_BIT] = ser_rx_irq & s_reg.pu;
    if (set[ST_TXI_BIT]) begin
      s_next.vtx = 1'b1;
    end
    if (set[ST_RXI_BIT]) begin
      s_next.vrx = 1'b1;
    end
    s_next.status = (s_reg.status & ~clr) | set;
    s_next.irq = |(s_next.status & s_next.ien);
    s_next.rx_ready = s_next.receiver_active & s_next.running & s_next.cmd_rxc &
                      ~s_next.rx_full;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_next_rst: s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata        = s_reg.prdata;
  assign pready        = s_reg.pready;
  assign pslverr       = s_reg.pslverr;
  assign irq           = s_reg.irq;
  assign bus_req       = s_reg.bus_req;
  assign mem_req       = s_reg.mem_req;
  assign mem_we        = s_reg.mem_we;
  assign mem_addr      = s_reg.mem_addr;
  assign mem_wdata     = s_reg.mem_wdata;
  assign tx_data       = s_reg.tx_data;
  assign tx_valid      = s_reg.tx_valid;
  assign rx_ready      = s_reg.rx_ready;
  assign ser_power_up  = s_reg.pu;
  assign ser_tx_reset  = s_reg.txrst;
  assign ser_rx_enable = s_reg.receiver_active;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_ACK_QINIT: assert property (
    s_reg.state == S_QINIT |=> s_reg.status[ST_ACK_BIT] && s_reg.vcfg)
    else $error("ack not set after queue init");
  AST_GNT_FIRST: assert property (
    s_reg.state == S_CHCFG |-> $past(s_reg.state) == S_BUSREQ && s_reg.bus_req)
    else $error("channel config without bus grant");
  AST_CFG_VEC: assert property (
    s_reg.state == S_CHCFG |=> s_reg.vcfg && s_reg.vcfg_code == VEC_CFG_CHAN
      && s_reg.status[ST_ACK_BIT])
    else $error("config vector not queued");
  AST_IRQ_OUT: assert property (
    s_reg.status[ST_ACK_BIT] && s_reg.ien[ST_ACK_BIT] |-> irq)
    else $error("irq missing for enabled ack");
  AST_BASE_FETCH: assert property (
    s_reg.state == S_CHCFG |=> mem_req && !mem_we && mem_addr == $past(s_reg.brxd))
    else $error("base rx descriptor not fetched");
  AST_RUN_AFTER: assert property (
    s_reg.state == S_FETCH_TX && done && s_reg.busy |=> s_reg.running && !bus_req)
    else $error("engine not running after config");
  AST_RX_GATE: assert property (
    rx_ready |-> s_reg.receiver_active && !s_reg.rx_full)
    else $error("rx accepted while receiver inactive");
  AST_W1C_ONLY: assert property (
    s_reg.status[ST_ACK_BIT] && !clr[ST_ACK_BIT] |=> s_reg.status[ST_ACK_BIT])
    else $error("status bit lost without clear");
  AST_ONE_REQ: assert property (
    s_reg.busy && !s_reg.cmd_pend |=> !s_reg.cmd_pend)
    else $error("command taken while busy");
  AST_STOP_HOLD: assert property (
    s_reg.state == S_TX_DATA && done && !s_reg.dma_control_select && s_reg.tx_link[DESC_STOP_BIT]
      |=> s_reg.tx_hold && s_reg.state == S_READY)
    else $error("stop bit ignored");
  AST_SER_VEC: assert property (
    ser_tx_irq && s_reg.pu |=> s_reg.vtx ##[0:40] (mem_req && mem_addr[31:12] == TXQ_BASE[31:12]))
    else $error("serial irq vector not posted");

  COV_QINIT: cover property (s_reg.state == S_QINIT);
  COV_CHCFG: cover property (s_reg.state == S_CHCFG ##[1:20] s_reg.running);
  COV_TX: cover property (tx_valid && tx_ready);
  COV_RX: cover property (rx_valid && rx_ready);
endmodule

/* tb_top.sv */
// tb_top: self-checking bench for the start-up sequencer
// assumes dss_pkg, dss_sequencer and dss_mem_model compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
    end \
  end
`define WAITC(c) \
  begin \
    int w; \
    for (w = 0; w < 500 && !((c) === 1'b1); w++) @(posedge mclk); \
    if (!((c) === 1'b1)) begin \
      bad_count++; \
      $display("unexpected wait expected 1 seen 0"); \
      test_done(); \
    end \
  end
module tb_top;
  import dss_pkg::*;
  localparam logic [31:0] CQ = 32'h0000_1000;
  localparam logic [31:0] TQ = 32'h0000_2000;
  localparam logic [31:0] RQ = 32'h0000_3000;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic        bus_req, bus_gnt, mem_req, mem_we, mem_ack, tx_valid, tx_ready;
  logic        rx_valid, rx_ready, ser_tx_irq, ser_rx_irq;
  logic        ser_power_up, ser_tx_reset, ser_rx_enable, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, tx_data, rx_data, rd;
  int          bad_count, check_count;
  dss_sequencer #(.CFGQ_BASE(CQ), .TXQ_BASE(TQ), .RXQ_BASE(RQ), .QIDX_W(4)) dss_sequencer_i (
    .mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .irq, .bus_req, .bus_gnt, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready,
    .ser_tx_irq, .ser_rx_irq, .ser_power_up, .ser_tx_reset, .ser_rx_enable
  );
  dss_mem_model #(.ACK_DLY(3)) dss_mem_model_i (
    .mclk, .rst, .bus_req, .bus_gnt, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack
  );
  function automatic logic [31:0] mw(input logic [31:0] a);
    return dss_mem_model_i.mem[a[13:2]];
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************
  // apb master: setup, access until pready
  // ****************************************
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int w;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (w = 0; w < 50; w++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    `CHK("pready", 1'b1, pready)
    if (pready !== 1'b1) begin
      test_done();
    end
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset();
    `CHK("irq", 1'b0, irq)
    apb(OFS_GSTAT, 1'b0, 32'h0);
    `CHK("gstat", 32'h0000_0000, rd)
    apb(8'h30, 1'b0, 32'h0);
    `CHK("pslverr", 1'b1, er)
    apb(OFS_GLOBAL_MODE_REG, 1'b1, 32'h0000_0001);
    apb(OFS_GLOBAL_MODE_REG, 1'b0, 32'h0);
    `CHK("global_mode_reg", 32'h0000_0001, rd)
    apb(OFS_GLOBAL_MODE_REG, 1'b1, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_qinit();
    apb(OFS_GIEN, 1'b1, 32'h0000_0001);
    apb(OFS_GCMD, 1'b1, 32'h0000_0003);
    `WAITC(irq)
    apb(OFS_GSTAT, 1'b0, 32'h0);
    `CHK("ack flag", 32'h0000_0001, rd)
    `WAITC(mw(CQ) === VEC_CFG_QINIT)
    `CHK("qinit vector", VEC_CFG_QINIT, mw(CQ))
    apb(OFS_GSTAT, 1'b1, 32'h0);
    apb(OFS_GSTAT, 1'b0, 32'h0);
    `CHK("gstat kept", 32'h0000_0001, rd)
    apb(OFS_GSTAT, 1'b1, 32'h0000_0001);
    apb(OFS_GSTAT, 1'b0, 32'h0);
    `CHK("gstat cleared", 32'h0000_0000, rd)
    `CHK("irq low", 1'b0, irq)
    $display("test qinit done");
  endtask
  task automatic t_power();
    apb(OFS_CCFG0, 1'b1, 32'h0000_0001);
    @(posedge mclk);
    `CHK("power up", 1'b1, ser_power_up)
    `CHK("rx enable", 1'b0, ser_rx_enable)
    apb(OFS_CCFG0, 1'b1, 32'h0000_0003);
    `WAITC(ser_tx_reset)
    apb(OFS_CCFG0, 1'b0, 32'h0);
    `CHK("ccfg0", 32'h0000_0001, rd)
    $display("test power done");
  endtask
  task automatic t_chan();
    dss_mem_model_i.mem[32'h100 >> 2] = 32'h8000_0000;
    dss_mem_model_i.mem[32'h200 >> 2] = 32'h8000_0000;
    dss_mem_model_i.mem[32'h204 >> 2] = 32'hCAFE_0001;
    rx_valid <= 1'b1;
    apb(OFS_BRXD, 1'b1, 32'h0000_0100);
    apb(OFS_BTXD, 1'b1, 32'h0000_0200);
    apb(OFS_GCMD, 1'b1, 32'h0000_000D);
    apb(OFS_GCMD, 1'b1, 32'h0000_0003);
    `WAITC(mem_req)
    `CHK("grant first", 1'b1, bus_gnt)
    `CHK("rx base fetch", 32'h0000_0100, mem_addr)
    `CHK("bus req held", 1'b1, bus_req)
    `WAITC(tx_valid)
    `CHK("bus released", 1'b0, bus_req)
    `CHK("tx word", 32'hCAFE_0001, tx_data)
    `CHK("rx held off", 1'b0, rx_ready)
    tx_ready <= 1'b1;
    @(posedge mclk);
    tx_ready <= 1'b0;
    `WAITC(mw(CQ + 32'h4) === VEC_CFG_CHAN)
    `CHK("chan vector", VEC_CFG_CHAN, mw(CQ + 32'h4))
    `CHK("busy cmd ignored", 32'h0000_0000, mw(CQ + 32'h8))
    apb(OFS_GSTAT, 1'b0, 32'h0);
    `CHK("chan ack", 32'h0000_0001, rd)
    apb(OFS_GSTAT, 1'b1, 32'h0000_0001);
    $display("test chan done");
  endtask
  task automatic t_rx();
    apb(OFS_CCFG2, 1'b1, 32'h0000_0001);
    @(posedge mclk);
    `CHK("rx enable", 1'b1, ser_rx_enable)
    `WAITC(rx_ready)
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
    `WAITC(mw(32'h104) === 32'h1234_5678)
    `CHK("rx stored", 32'h1234_5678, mw(32'h104))
    $display("test rx done");
  endtask
  task automatic t_irq();
    apb(OFS_GIEN, 1'b1, 32'h0000_0007);
    ser_tx_irq <= 1'b1;
    @(posedge mclk);
    ser_tx_irq <= 1'b0;
    `WAITC(mw(TQ) === VEC_TX)
    `CHK("tx vector", VEC_TX, mw(TQ))
    ser_rx_irq <= 1'b1;
    @(posedge mclk);
    ser_rx_irq <= 1'b0;
    `WAITC(mw(RQ) === VEC_RX)
    `CHK("rx vector", VEC_RX, mw(RQ))
    apb(OFS_GSTAT, 1'b0, 32'h0);
    `CHK("gstat irqs", 32'h0000_0006, rd)
    `CHK("irq high", 1'b1, irq)
    apb(OFS_GCLR, 1'b1, 32'h0000_0006);
    apb(OFS_GSTAT, 1'b0, 32'h0);
    `CHK("gstat clear", 32'h0000_0000, rd)
    $display("test irq done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {rst, psel, penable, pwrite, tx_ready, rx_valid, ser_tx_irq, ser_rx_irq} = 8'hFF;
    {psel, penable, pwrite, tx_ready, rx_valid, ser_tx_irq, ser_rx_irq} = 7'h00;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    rx_data     = 32'h1234_5678;
    bad_count   = 0;
    check_count = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_qinit();
    t_power();
    t_chan();
    t_rx();
    t_irq();
    test_done();
  end
endmodule
